// File: include/fsp_pkg.sv
// Constants and carrier types for the flash status/protect/ident block.
// Assumes a 50 MHz core clock and a 32-bit AXI4-Lite register bus.
package fsp_pkg;

   // ---------------------------------------------------------------
   // Serial command opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_STATUS_ARM = 8'h50;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_JEDEC_ID = 8'h9f;
   localparam logic [7:0] OP_LEGACY_ID_A = 8'h90;
   localparam logic [7:0] OP_LEGACY_ID_B = 8'hab;

   // ---------------------------------------------------------------
   // Register map (byte addresses) and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IDENT = 8'h04;
   localparam logic [7:0] REG_CTRL = 8'h08;
   localparam int CTRL_PROG = 0;
   localparam int CTRL_AUTO_INC = 1;
   localparam int ST_ARMED = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Identification bytes after reset; values are arbitrary
   localparam logic [7:0] MANUF_CODE_RESET = 8'h5a;
   localparam logic [7:0] MEM_TYPE_RESET = 8'h3c;
   localparam logic [7:0] CAPACITY_RESET = 8'h14;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int BYTE_PROG_NS = 10000;
   localparam int BYTE_PROG_CYC = BYTE_PROG_NS / CLK_PERIOD_NS;
   localparam int BUSY_W = 10;

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic lock;
      logic autoInc;
      logic [3:0] protect;
      logic wrEnLatch;
      logic busy;
   } fsp_status_t;

   typedef struct packed {
      logic [7:0] capacity;
      logic [7:0] memType;
      logic [7:0] manuf;
   } fsp_ident_t;

   typedef enum logic [2:0] {
      MODE_CMD = 3'b001,
      MODE_JEDEC = 3'b010,
      MODE_LEGACY = 3'b100
   } fsp_mode_t;

endpackage

// File: verilog/fsp_status_protect.sv
// Serial flash command decoder: write disable/enable, guarded status
// write with lock-down pin, and the two identification readouts.
// Assumes SPI mode 0 pins from outside, sampled by core_clk, which must
// run well above four times the serial clock; registers on AXI4-Lite.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps

// Overview of operation
// - Write disable clears write-enable latch and auto-increment flag.
// - Write disable leaves a running byte program to finish.
// - Write disable acts only at the chip-enable rising edge.
// - Arm command enables the status write that must follow next.
// - Status write loads four protect bits and lock from data byte.
// - Status write commits only at the ending chip-enable rise.
// - Status write ignored when protect pin low and lock set.
// - With protect pin low, lock may go 0 to 1 only.
// - With protect pin high, lock and protect bits all writable.
// - Permission judged from lock and pin before the ending edge.
// - One allowed write may set lock and protect bits together.
// - Opcode 9fh returns maker byte, memory type, capacity.
// - Raising chip enable ends readout and releases the output.
// - Opcodes 90h and abh start legacy ident with 24-bit address.
// - Legacy ident: address 0 maker, 1 device code, alternating.
// - Write disable decoded from opcode 04h.
// - Write enable also arms status write; latch cleared at its end.
module fsp_status_protect (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ceN,
   input wire logic sck,
   input wire logic si,
   input wire logic wpN,
   output logic soOut,
   output logic soOe,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic ceS1, ceS2, ceDly, sckS1, sckS2, sckDly, siS1, siS2, wpS1, wpS2;
   logic ceRise, sckRise, sckFall, byteDone, cmdEnd, writeFire;
   logic [7:0] nextByte;

   // Two flops per pin; edges only look at the second stage onward
   always_ff @(posedge core_clk) begin
      if (rst) begin
         {ceS1, ceS2, ceDly} <= 3'h7;
         {sckS1, sckS2, sckDly} <= 3'h0;
         {siS1, siS2, wpS1, wpS2} <= 4'h0;
      end else begin
         {ceS1, ceS2, ceDly} <= {ceN, ceS1, ceS2};
         {sckS1, sckS2, sckDly} <= {sck, sckS1, sckS2};
         {siS1, siS2, wpS1, wpS2} <= {si, siS1, wpN, wpS1};
      end
   end

   assign ceRise = ceS2 && !ceDly;
   assign sckRise = sckS2 && !sckDly && !ceS2;
   assign sckFall = !sckS2 && sckDly && !ceS2;

   // ---------------------------------------------------------------
   // Serial input framing
   // ---------------------------------------------------------------
   logic [2:0] bitCnt, byteCnt;
   logic [7:0] shiftIn, opcode, dataByte;

   assign nextByte = {shiftIn[6:0], siS2};
   assign byteDone = sckRise && bitCnt == 3'h7;
   // Partial bytes never count as a command
   assign cmdEnd = ceRise && bitCnt == 3'h0 && byteCnt != 3'h0;

   // Bit and byte counters restart whenever chip enable is high
   always_ff @(posedge core_clk) begin
      if (rst || ceS2) begin
         bitCnt <= 3'h0;
         byteCnt <= 3'h0;
         shiftIn <= 8'h00;
      end else if (sckRise) begin
         shiftIn <= nextByte;
         bitCnt <= bitCnt + 3'h1;
         if (bitCnt == 3'h7 && byteCnt != 3'h7) begin
            byteCnt <= byteCnt + 3'h1;
         end
      end
   end

   // Opcode and status data byte capture
   always_ff @(posedge core_clk) begin
      if (rst) begin
         opcode <= 8'h00;
         dataByte <= 8'h00;
      end else if (byteDone) begin
         if (byteCnt == 3'h0) begin
            opcode <= nextByte;
         end
         if (byteCnt == 3'h1) begin
            dataByte <= nextByte;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status bits and command execution
   // ---------------------------------------------------------------
   localparam int BW = fsp_pkg::BUSY_W;
   logic wrEnLatch, autoInc, lock, armed, autoIncSet, progStart;
   logic [3:0] protect;
   logic [BW-1:0] busyCnt;
   fsp_pkg::fsp_status_t statusView;

   assign statusView = '{lock: lock, autoInc: autoInc, protect: protect,
      wrEnLatch: wrEnLatch, busy: busyCnt != '0};

   // Commands act only at the rising chip-enable edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         {wrEnLatch, autoInc, lock, armed} <= 4'h0;
         protect <= 4'h0;
      end else begin
         if (cmdEnd) begin
            unique case (opcode)
               fsp_pkg::OP_WRITE_DISABLE: begin
                  wrEnLatch <= 1'b0;
                  autoInc <= 1'b0;
                  armed <= 1'b0;
               end
               fsp_pkg::OP_WRITE_ENABLE: begin
                  wrEnLatch <= 1'b1;
                  armed <= 1'b1;
               end
               fsp_pkg::OP_STATUS_ARM: armed <= 1'b1;
               fsp_pkg::OP_STATUS_WRITE: begin
                  armed <= 1'b0;
                  wrEnLatch <= 1'b0;
                  // Pin low and lock set refuses; otherwise lock was 0
                  // or the pin is high, so a plain load is safe
                  if (armed && byteCnt >= 3'h2 &&
                      !(!wpS2 && lock)) begin
                     protect <= dataByte[5:2];
                     lock <= dataByte[7];
                  end
               end
               default: armed <= 1'b0;
            endcase
         end
         // Software entry into auto-increment wins over a clear
         if (autoIncSet) begin
            autoInc <= 1'b1;
         end
      end
   end

   // Program timer runs on regardless of write disable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busyCnt <= '0;
      end else if (progStart && busyCnt == '0) begin
         busyCnt <= BW'(fsp_pkg::BYTE_PROG_CYC);
      end else if (busyCnt != '0) begin
         busyCnt <= busyCnt - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Identification readout
   // ---------------------------------------------------------------
   fsp_pkg::fsp_mode_t mode;
   fsp_pkg::fsp_ident_t ident;
   logic [7:0] outShift;
   logic [1:0] outSel;
   logic outActive;

   // Byte reload at rising sck, bit shift at falling sck (mode 0)
   always_ff @(posedge core_clk) begin
      if (rst || ceS2) begin
         mode <= fsp_pkg::MODE_CMD;
         outShift <= 8'h00;
         outSel <= 2'h0;
         outActive <= 1'b0;
         soOut <= 1'b0;
         soOe <= 1'b0;
      end else if (byteDone) begin
         unique case (mode)
            fsp_pkg::MODE_CMD: begin
               if (byteCnt == 3'h0 && nextByte == fsp_pkg::OP_JEDEC_ID) begin
                  mode <= fsp_pkg::MODE_JEDEC;
                  outShift <= ident.manuf;
                  outSel <= 2'h1;
                  outActive <= 1'b1;
               end else if (byteCnt == 3'h0 &&
                  (nextByte == fsp_pkg::OP_LEGACY_ID_A ||
                   nextByte == fsp_pkg::OP_LEGACY_ID_B)) begin
                  mode <= fsp_pkg::MODE_LEGACY;
               end
            end
            fsp_pkg::MODE_JEDEC: begin
               outShift <= outSel == 2'h1 ? ident.memType :
                  outSel == 2'h2 ? ident.capacity : ident.manuf;
               outSel <= outSel == 2'h2 ? 2'h0 : outSel + 2'h1;
            end
            fsp_pkg::MODE_LEGACY: begin
               // Last address byte picks the start, then alternate
               if (byteCnt == 3'h3) begin
                  outShift <= nextByte[0] ? ident.capacity : ident.manuf;
                  outSel <= {1'b0, !nextByte[0]};
                  outActive <= 1'b1;
               end else if (byteCnt > 3'h3) begin
                  outShift <= outSel[0] ? ident.capacity : ident.manuf;
                  outSel <= {1'b0, !outSel[0]};
               end
            end
         endcase
      end else if (sckFall && outActive) begin
         soOut <= outShift[7];
         soOe <= 1'b1;
         outShift <= {outShift[6:0], 1'b0};
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic awHeld, wHeld;
   logic [7:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;

   assign writeFire = awHeld && wHeld && !bvalid;
   assign autoIncSet = writeFire && awAddrQ == fsp_pkg::REG_CTRL &&
      wStrbQ[0] && wDataQ[fsp_pkg::CTRL_AUTO_INC];
   // A program start needs the write-enable latch
   assign progStart = writeFire && awAddrQ == fsp_pkg::REG_CTRL &&
      wStrbQ[0] && wDataQ[fsp_pkg::CTRL_PROG] && wrEnLatch;

   // Address and data taken in either order, answered after both
   always_ff @(posedge core_clk) begin
      if (rst) begin
         {awready, wready} <= 2'h3;
         {awHeld, wHeld, bvalid} <= 3'h0;
         bresp <= fsp_pkg::RESP_OKAY;
         awAddrQ <= 8'h00;
         wDataQ <= 32'h0;
         wStrbQ <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awAddrQ <= awaddr;
            awready <= 1'b0;
            awHeld <= 1'b1;
         end
         if (wvalid && wready) begin
            wDataQ <= wdata;
            wStrbQ <= wstrb;
            wready <= 1'b0;
            wHeld <= 1'b1;
         end
         if (writeFire) begin
            bvalid <= 1'b1;
            {awHeld, wHeld} <= 2'h0;
            bresp <= (awAddrQ == fsp_pkg::REG_IDENT ||
               awAddrQ == fsp_pkg::REG_CTRL ||
               awAddrQ == fsp_pkg::REG_STATUS) ?
               fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            {awready, wready} <= 2'h3;
         end
      end
   end

   // Ident bytes writable per byte lane; steers the readout
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ident <= '{capacity: fsp_pkg::CAPACITY_RESET,
            memType: fsp_pkg::MEM_TYPE_RESET,
            manuf: fsp_pkg::MANUF_CODE_RESET};
      end else if (writeFire && awAddrQ == fsp_pkg::REG_IDENT) begin
         for (int b = 0; b < 3; b++) begin
            if (wStrbQ[b]) begin
               ident[b*8 +: 8] <= wDataQ[b*8 +: 8];
            end
         end
      end
   end

   // Single-cycle read answer; unmapped reads give zero and an error
   always_ff @(posedge core_clk) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= fsp_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= fsp_pkg::RESP_OKAY;
         unique case (araddr)
            fsp_pkg::REG_STATUS:
               rdata <= {23'h0, armed, statusView};
            fsp_pkg::REG_IDENT: rdata <= {8'h00, ident};
            fsp_pkg::REG_CTRL: rdata <= {30'h0, autoInc, busyCnt != '0};
            default: begin
               rdata <= 32'h0;
               rresp <= fsp_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_wr_dis_clear;
      cmdEnd && opcode == 8'h04 && !autoIncSet |=> !wrEnLatch && !autoInc;
   endproperty
   a_wr_dis_clear: assert property (p_wr_dis_clear)
      else $error("write disable left latch or flag set");

   property p_prog_runs;
      cmdEnd && opcode == 8'h04 && busyCnt > 10'd1 |=> busyCnt != '0;
   endproperty
   a_prog_runs: assert property (p_prog_runs)
      else $error("write disable aborted program");

   property p_latch_edge;
      $changed(wrEnLatch) |-> $past(cmdEnd);
   endproperty
   a_latch_edge: assert property (p_latch_edge)
      else $error("latch changed away from chip-enable rise");

   property p_locked;
      cmdEnd && opcode == 8'h01 && !wpS2 && lock
         |=> $stable(protect) && lock;
   endproperty
   a_locked: assert property (p_locked)
      else $error("locked status register was written");

   property p_lock_hold;
      !wpS2 && lock |=> lock;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lock cleared with protect pin low");

   property p_st_write_load;
      cmdEnd && opcode == 8'h01 && armed && wpS2 && byteCnt >= 3'h2
         |=> protect == $past(dataByte[5:2]) &&
             lock == $past(dataByte[7]) && !wrEnLatch;
   endproperty
   a_st_write_load: assert property (p_st_write_load)
      else $error("status write did not load");

   property p_arm_drop;
      cmdEnd && opcode != 8'h06 && opcode != 8'h50 |=> !armed;
   endproperty
   a_arm_drop: assert property (p_arm_drop)
      else $error("arm survived another command");

   property p_so_release;
      ceS2 |=> !soOe;
   endproperty
   a_so_release: assert property (p_so_release)
      else $error("output driven with chip enable high");

   c_jedec: cover property (mode == fsp_pkg::MODE_JEDEC && outSel == 2'h0);
   c_legacy: cover property (mode == fsp_pkg::MODE_LEGACY && soOe);
   c_st_write_ok: cover property (cmdEnd && opcode == 8'h01 && armed);
   c_refused: cover property (cmdEnd && opcode == 8'h01 && !wpS2 && lock);

endmodule // fsp_status_protect

// File: testbench/fsp_spi_host.sv
// SPI host model that frames commands for the flash command block.
// Assumes mode 0 and a 160 ns serial clock held low between frames.
`timescale 1ns/10ps
module fsp_spi_host (
   input wire logic core_clk,
   output logic ceN,
   output logic sck,
   output logic si,
   input wire logic soOut
);
   // ----------------------------------------
   // Pin driving tasks
   // ----------------------------------------
   // Idle: deselected, serial clock still
   initial begin
      ceN = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end

   // Select right after a core edge, like every pin change here
   task automatic open_frame();
      @(posedge core_clk);
      ceN <= 1'b0;
   endtask

   // One byte each way, MSB first; four core clocks per sck phase
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si <= tx[i];
         repeat (4) @(posedge core_clk);
         sck <= 1'b1;
         rx[i] = soOut;
         repeat (4) @(posedge core_clk);
         sck <= 1'b0;
      end
   endtask

   // Deselect ends the command; si shows a changed level once released
   task automatic close_frame();
      repeat (4) @(posedge core_clk);
      ceN <= 1'b1;
      si <= ~si;
      repeat (16) @(posedge core_clk);
   endtask
endmodule // fsp_spi_host

// File: testbench/fsp_status_protect_tb.sv
// Self-checking bench for the flash status/protect/ident block.
// Assumes fsp_spi_host as the serial host and AXI4-Lite on core_clk.
`timescale 1ns/10ps
module fsp_status_protect_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic wpN = 1'b1;
   logic ceN, sck, si, soOut, soOe;
   // Released output shows the inverse, so a missing enable is caught
   logic soLine;
   assign soLine = soOe ? soOut : ~soOut;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx, maker;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp, rsp;
   int errors = 0, cmp_count = 0;
   fsp_pkg::fsp_status_t st;

   always #(fsp_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   fsp_status_protect u_fsp_status_protect (.core_clk(core_clk),
      .rst(rst), .ceN(ceN), .sck(sck), .si(si), .wpN(wpN),
      .soOut(soOut), .soOe(soOe), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   fsp_spi_host u_fsp_spi_host (.core_clk(core_clk), .ceN(ceN),
      .sck(sck), .si(si), .soOut(soLine));

   // ----------------------------------------
   // Reporting and comparison
   // ----------------------------------------
   task automatic complete_run();
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic hang();
      errors++;
      $display("unexpected at %0t: no answer in time", $time);
      complete_run();
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: so byte %h, wanted %h", $time, got, exp);
      end
   endtask

   // ----------------------------------------
   // Bus and serial helpers
   // ----------------------------------------
   // Address and data offered together; bready held until bvalid seen
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
      bit aw;
      bit w;
      int n;
      @(posedge core_clk);
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge core_clk);
         if (aw && w && bvalid === 1'b1) break;
         if (awready === 1'b1) aw = 1'b1;
         if (wready === 1'b1) w = 1'b1;
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      if (n == 64) hang();
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      bit ar;
      int n;
      @(posedge core_clk);
      ar = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge core_clk);
         if (ar && rvalid === 1'b1) break;
         if (arready === 1'b1) ar = 1'b1;
         if (ar) arvalid <= 1'b0;
      end
      if (n == 64) hang();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // Status word is the armed flag above the packed status byte
   task automatic chk_st(input logic armed);
      axi_read(fsp_pkg::REG_STATUS, rd, rsp);
      chk_word(rd, {23'h0, armed, st});
   endtask

   task automatic cmd(input logic [7:0] op);
      u_fsp_spi_host.open_frame();
      u_fsp_spi_host.xfer(op, rx);
      u_fsp_spi_host.close_frame();
   endtask

   // Status write; protect pin set mid-frame, old fields kept until end
   task automatic status_write_cmd(input logic [7:0] d, input logic wpLate);
      u_fsp_spi_host.open_frame();
      u_fsp_spi_host.xfer(fsp_pkg::OP_STATUS_WRITE, rx);
      u_fsp_spi_host.xfer(d, rx);
      @(posedge core_clk);
      wpN <= wpLate;
      repeat (6) @(posedge core_clk);
      axi_read(fsp_pkg::REG_STATUS, rd, rsp);
      chk_word(rd & 32'hbc, {24'h0, st} & 32'hbc);
      u_fsp_spi_host.close_frame();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_jedec();
      logic [7:0] e [4];
      e = '{fsp_pkg::MANUF_CODE_RESET, fsp_pkg::MEM_TYPE_RESET,
         fsp_pkg::CAPACITY_RESET, fsp_pkg::MANUF_CODE_RESET};
      axi_read(fsp_pkg::REG_IDENT, rd, rsp);
      chk_word(rd, {8'h0, e[2], e[1], e[0]});
      u_fsp_spi_host.open_frame();
      u_fsp_spi_host.xfer(fsp_pkg::OP_JEDEC_ID, rx);
      for (int i = 0; i < 4; i++) begin
         u_fsp_spi_host.xfer(8'h00, rx);
         chk_byte(rx, e[i]);
      end
      chk_word({31'h0, soOe}, 32'h1);
      u_fsp_spi_host.close_frame();
      chk_word({31'h0, soOe}, 32'h0);
   endtask

   // Lane write to the maker byte, then unmapped accesses are refused
   task automatic t_regs();
      maker = 8'ha7;
      axi_write(fsp_pkg::REG_IDENT, 32'hffffffa7, 4'h1, rsp);
      chk_word({30'h0, rsp}, {30'h0, fsp_pkg::RESP_OKAY});
      axi_read(fsp_pkg::REG_IDENT, rd, rsp);
      chk_word(rd, {8'h0, fsp_pkg::CAPACITY_RESET,
         fsp_pkg::MEM_TYPE_RESET, maker});
      axi_write(8'h0c, 32'h1, 4'hf, rsp);
      chk_word({30'h0, rsp}, {30'h0, fsp_pkg::RESP_SLVERR});
      axi_read(8'h0c, rd, rsp);
      chk_word({rd, rsp}, {32'h0, fsp_pkg::RESP_SLVERR});
   endtask

   // Both legacy opcodes, starting at address 0 and at address 1
   task automatic t_legacy();
      logic [7:0] e [2];
      e = '{maker, fsp_pkg::CAPACITY_RESET};
      for (int k = 0; k < 2; k++) begin
         u_fsp_spi_host.open_frame();
         u_fsp_spi_host.xfer(k ? fsp_pkg::OP_LEGACY_ID_B :
            fsp_pkg::OP_LEGACY_ID_A, rx);
         u_fsp_spi_host.xfer(8'h00, rx);
         u_fsp_spi_host.xfer(8'h00, rx);
         u_fsp_spi_host.xfer({7'h0, k[0]}, rx);
         for (int j = 0; j < 3; j++) begin
            u_fsp_spi_host.xfer(8'h00, rx);
            chk_byte(rx, e[(j + k) % 2]);
         end
         u_fsp_spi_host.close_frame();
      end
   endtask

   task automatic t_guard();
      status_write_cmd(8'h3c, 1'b1);
      chk_st(1'b0);
      cmd(fsp_pkg::OP_STATUS_ARM);
      chk_st(1'b1);
      status_write_cmd(8'h3c, 1'b1);
      st.protect = 4'hf;
      chk_st(1'b0);
      cmd(fsp_pkg::OP_STATUS_ARM);
      cmd(fsp_pkg::OP_JEDEC_ID);
      status_write_cmd(8'h00, 1'b1);
      chk_st(1'b0);
      cmd(fsp_pkg::OP_WRITE_ENABLE);
      st.wrEnLatch = 1'b1;
      chk_st(1'b1);
      status_write_cmd(8'h10, 1'b1);
      st.protect = 4'h4;
      st.wrEnLatch = 1'b0;
      chk_st(1'b0);
   endtask

   // Lock with pin low, refused unlock, then pin raised mid-frame
   task automatic t_lock();
      @(posedge core_clk);
      wpN <= 1'b0;
      cmd(fsp_pkg::OP_STATUS_ARM);
      status_write_cmd(8'h88, 1'b0);
      st.lock = 1'b1;
      st.protect = 4'h2;
      chk_st(1'b0);
      cmd(fsp_pkg::OP_STATUS_ARM);
      status_write_cmd(8'h00, 1'b0);
      chk_st(1'b0);
      cmd(fsp_pkg::OP_STATUS_ARM);
      status_write_cmd(8'h04, 1'b1);
      st.lock = 1'b0;
      st.protect = 4'h1;
      chk_st(1'b0);
   endtask

   // Write disable during a running byte program
   task automatic t_disable();
      int n;
      cmd(fsp_pkg::OP_WRITE_ENABLE);
      axi_write(fsp_pkg::REG_CTRL, 32'h3, 4'hf, rsp);
      st.wrEnLatch = 1'b1;
      st.autoInc = 1'b1;
      st.busy = 1'b1;
      chk_st(1'b1);
      u_fsp_spi_host.open_frame();
      u_fsp_spi_host.xfer(fsp_pkg::OP_WRITE_DISABLE, rx);
      repeat (6) @(posedge core_clk);
      chk_st(1'b1);
      u_fsp_spi_host.close_frame();
      st.wrEnLatch = 1'b0;
      st.autoInc = 1'b0;
      chk_st(1'b0);
      for (n = 0; n < 300; n++) begin
         axi_read(fsp_pkg::REG_CTRL, rd, rsp);
         if (rd[fsp_pkg::CTRL_PROG] === 1'b0) break;
      end
      if (n == 300) hang();
   endtask

   // Main sequence: reset, settle pins, then each scenario in turn
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      st = '0;
      chk_st(1'b0);
      t_jedec();
      t_regs();
      t_legacy();
      t_guard();
      t_lock();
      t_disable();
      complete_run();
   end
endmodule // fsp_status_protect_tb
